// File: design/ahs_channel_status.sv
// Purpose: One async HDLC channel: control registers, in-band flow control, transmitter and status register.
// Assumes: Receive engine supplies decoded characters and line activity; inputs synchronous to REF_CLK.
// Notes:   Status is sampled every cycle; reading it changes nothing.
//
// Design decisions made here: the placing of the registers and the strobed register port.
`include "ahs_defines.svh"
module ahs_channel_status #(
  parameter int BAUD_DIV = `AHS_BAUD_DIV
) (
  // Clock and reset
  input  wire logic                 REF_CLK,
  input  wire logic                 ARST_N,
  // Register port
  input  wire logic [7:0]           REG_ADDR,
  input  wire logic [7:0]           REG_WDATA,
  input  wire logic                 REG_WR,
  input  wire logic                 REG_RD,
  output logic [7:0]                REG_RDATA,
  // Transmit character source
  input  wire logic                 TX_CHAR_VALID,
  input  wire ahs_pkg::ahs_txchar_s TX_CHAR,
  output logic                      TX_CHAR_READY,
  // Serial output
  output logic                      TXD,
  // Receive engine
  input  wire logic                 RX_CHAR_VALID,
  input  wire logic [7:0]           RX_CHAR,
  input  wire logic                 RX_LINE_BUSY,
  input  wire logic                 RX_FRAME_ACTIVE,
  // Status copy for the channel's own use
  output ahs_pkg::ahs_status_s      STATUS
);
  import ahs_pkg::*;

  localparam int DIV_W = $clog2(BAUD_DIV + 1);

  // Control state
  logic [7:0]       ctrl_reg, ctrl_next;
  logic [7:0]       opt2_reg, opt2_next;
  logic             floff_reg, floff_next;
  // Bus read data
  logic [7:0]       rdata_reg, rdata_next;
  // Status sampling
  ahs_status_s      status_reg, status_next;
  // Bit-rate divider
  logic [DIV_W-1:0] div_reg, div_next;
  logic             tick_reg, tick_next;
  // Engine outputs
  logic             eng_ready;
  logic             eng_txd;
  logic             eng_frame;
  logic             eng_busy;
  // Decoded events
  logic             tx_en;
  logic             rx_en;
  logic             inband_en;
  logic             wr_ctrl;
  logic             tx_en_toggle;
  logic             xoff_seen;
  logic             xon_seen;

  assign tx_en     = ctrl_reg[`AHS_CTRL_TX_EN_BIT];
  assign rx_en     = ctrl_reg[`AHS_CTRL_RX_EN_BIT];
  assign inband_en = opt2_reg[`AHS_OPT2_INBAND_BIT];
  assign wr_ctrl   = REG_WR && (REG_ADDR == `AHS_OFS_CTRL);

  // Enabling or disabling the transmitter drops a stale flow-off state
  assign tx_en_toggle = wr_ctrl && (REG_WDATA[`AHS_CTRL_TX_EN_BIT] != tx_en);

  // Flow characters only count while the receiver and the in-band option are on
  assign xoff_seen = RX_CHAR_VALID && rx_en && inband_en && ahs_char_is(RX_CHAR, `AHS_CHAR_XOFF);
  assign xon_seen  = RX_CHAR_VALID && rx_en && inband_en && ahs_char_is(RX_CHAR, `AHS_CHAR_XON);

  // Register writes
  always_comb begin
    ctrl_next = ctrl_reg;
    opt2_next = opt2_reg;
    if (REG_WR) begin
      case (REG_ADDR)
        `AHS_OFS_CTRL: ctrl_next = REG_WDATA;
        `AHS_OFS_OPT2: opt2_next = REG_WDATA;
        default: begin
          ctrl_next = ctrl_reg;
          opt2_next = opt2_reg;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_reg <= `AHS_CTRL_RESET;
      opt2_reg <= `AHS_OPT2_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
      opt2_reg <= opt2_next;
    end
  end

  // Flow-off flag: a received Xoff wins over any clear in the same cycle
  always_comb begin
    floff_next = floff_reg;
    if (xon_seen || tx_en_toggle) begin
      floff_next = 1'b0;
    end
    if (xoff_seen) begin
      floff_next = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      floff_reg <= 1'b0;
    end else begin
      floff_reg <= floff_next;
    end
  end

  // Bit-rate divider, one-cycle tick per bit time
  always_comb begin
    div_next  = div_reg;
    tick_next = 1'b0;
    if (div_reg == DIV_W'(BAUD_DIV - 1)) begin
      div_next  = '0;
      tick_next = 1'b1;
    end else begin
      div_next = div_reg + DIV_W'(1);
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_next;
      tick_reg <= tick_next;
    end
  end

  // Transmitter; flow stop acts only when the in-band option is set
  ahs_tx_engine u_tx (
    .clk          (REF_CLK),
    .arst_n       (ARST_N),
    .tick         (tick_reg),
    .enable       (tx_en),
    .flow_stop    (floff_reg && inband_en),
    .char_valid   (TX_CHAR_VALID),
    .char_in      (TX_CHAR),
    .char_ready   (eng_ready),
    .txd          (eng_txd),
    .frame_active (eng_frame),
    .line_busy    (eng_busy)
  );

  // Status sampled from live state every cycle
  always_comb begin
    status_next                      = '0;
    status_next.rx_enabled_flag      = rx_en;
    // Receive flow-off belongs to the receive command path, not built here
    status_next.rx_flow_stopped_flag = 1'b0;
    status_next.rx_frame_active_flag = rx_en && RX_FRAME_ACTIVE;
    status_next.rx_idle_flag         = !RX_LINE_BUSY && !(rx_en && RX_FRAME_ACTIVE);
    status_next.tx_enabled_flag      = tx_en;
    // Reported as held; software ignores it while the in-band option is off
    status_next.tx_flow_stopped_flag = floff_reg;
    status_next.tx_frame_active_flag = eng_frame;
    status_next.tx_idle_flag         = !eng_frame && !eng_busy;
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      status_reg <= `AHS_STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_comb begin
    rdata_next = 8'h00;
    if (REG_RD) begin
      case (REG_ADDR)
        `AHS_OFS_CTRL:   rdata_next = ctrl_reg;
        `AHS_OFS_OPT2:   rdata_next = opt2_reg;
        `AHS_OFS_STATUS: rdata_next = status_reg;
        default:         rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign REG_RDATA     = rdata_reg;
  assign TX_CHAR_READY = eng_ready;
  assign TXD           = eng_txd;
  assign STATUS        = status_reg;

endmodule

// File: inc/ahs_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts for the async HDLC channel status block.
// Assumes: 8-bit register port, one 20 MHz clock.
// Notes:   Overview of operation follows.
//
// Overview of operation
// - Transmitter enable bit mirrors transmitter state
// - Flow-off bit meaningful only with in-band enable
// - Received Xoff stops data, sets flow-off bit
// - Flow-off clear lets waiting characters go
// - Frame bit set while frame is transmitting
// - Transmit idle bit follows output idle
// - Receive idle bit follows input idle
// - Transmit frame and idle never both set
// - Receive frame and idle never both set
// - Status register reads zero after reset; here it reads 11h (both idle bits) from the first sample after reset
`ifndef AHS_DEFINES_SVH
`define AHS_DEFINES_SVH

// Register offsets
`define AHS_OFS_CTRL          8'h00
`define AHS_OFS_OPT2          8'h01
`define AHS_OFS_STATUS        8'h02

// Control register fields
`define AHS_CTRL_TX_EN_BIT    0
`define AHS_CTRL_RX_EN_BIT    1
`define AHS_CTRL_RESET        8'h00

// Option register two fields
`define AHS_OPT2_INBAND_BIT   0
`define AHS_OPT2_RESET        8'h00

// Status register reset value
`define AHS_STATUS_RESET      8'h00

// Flow control and framing characters
`define AHS_CHAR_XOFF         8'h13
`define AHS_CHAR_XON          8'h11
`define AHS_CHAR_FLAG         8'h7e
`define AHS_CHAR_ESC          8'h7d
`define AHS_ESC_XOR           8'h20

// Bit timing: 8N1 character plus one extra mark slot
`define AHS_CLK_HZ            20000000
`define AHS_BAUD              115200
`define AHS_BAUD_DIV          (`AHS_CLK_HZ / `AHS_BAUD)
`define AHS_CHAR_SLOTS        4'd11

`endif

// File: inc/ahs_pkg.sv
// Purpose: Types shared by the async HDLC channel status block.
// Assumes: Constants come from ahs_defines.svh.
// Notes:   Status struct layout is the status register layout, bit 7 first.
package ahs_pkg;

  typedef enum logic [2:0] {
    TX_IDLE,
    TX_DATA,
    TX_ESC,
    TX_CLOSE,
    TX_END
  } ahs_tx_state_e;

  typedef struct packed {
    logic rx_enabled_flag;
    logic rx_flow_stopped_flag;
    logic rx_frame_active_flag;
    logic rx_idle_flag;
    logic tx_enabled_flag;
    logic tx_flow_stopped_flag;
    logic tx_frame_active_flag;
    logic tx_idle_flag;
  } ahs_status_s;

  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } ahs_txchar_s;

  function automatic logic ahs_char_is(input logic [7:0] c, input logic [7:0] ref_c);
    ahs_char_is = (c == ref_c);
  endfunction

endpackage

// File: design/ahs_tx_engine.sv
// Purpose: Async HDLC transmitter: opening flag, escaped data, closing flag, 8N1 serial.
// Assumes: tick is a one-cycle pulse per bit time.
// Notes:   Flow stop holds off the next data character; a character on the line always completes.
`include "ahs_defines.svh"
module ahs_tx_engine (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               arst_n,
  // Control
  input  wire logic               tick,
  input  wire logic               enable,
  input  wire logic               flow_stop,
  // Character source
  input  wire logic               char_valid,
  input  wire ahs_pkg::ahs_txchar_s char_in,
  output logic                    char_ready,
  // Line and state
  output logic                    txd,
  output logic                    frame_active,
  output logic                    line_busy
);
  import ahs_pkg::*;

  ahs_tx_state_e state_reg, state_next;
  logic [10:0]   shift_reg, shift_next;
  logic [3:0]    cnt_reg, cnt_next;
  logic [7:0]    esc_reg, esc_next;
  logic          last_reg, last_next;
  logic          txd_reg, txd_next;
  logic          ready_reg, ready_next;
  logic          load;
  logic [7:0]    load_byte;
  logic          take;

  function automatic logic needs_escape(input logic [7:0] c);
    needs_escape = ahs_char_is(c, `AHS_CHAR_FLAG) || ahs_char_is(c, `AHS_CHAR_ESC);
  endfunction

  assign take = char_valid && ready_reg;

  always_comb begin
    state_next = state_reg;
    esc_next   = esc_reg;
    last_next  = last_reg;
    load       = 1'b0;
    load_byte  = `AHS_CHAR_FLAG;
    if (cnt_reg == 4'h0) begin
      case (state_reg)
        TX_IDLE: begin
          if (enable && char_valid && !flow_stop) begin
            load       = 1'b1;
            state_next = TX_DATA;
          end
        end
        TX_DATA: begin
          // An offer made before a disable still completes, so no accepted character is lost
          if (take) begin
            load      = 1'b1;
            last_next = char_in.last;
            if (needs_escape(char_in.data)) begin
              load_byte  = `AHS_CHAR_ESC;
              esc_next   = char_in.data ^ `AHS_ESC_XOR;
              state_next = TX_ESC;
            end else begin
              load_byte  = char_in.data;
              state_next = char_in.last ? TX_CLOSE : TX_DATA;
            end
          end else if (!enable) begin
            state_next = TX_CLOSE;
          end
        end
        TX_ESC: begin
          load       = 1'b1;
          load_byte  = esc_reg;
          state_next = last_reg ? TX_CLOSE : TX_DATA;
        end
        TX_CLOSE: begin
          load       = 1'b1;
          state_next = TX_END;
        end
        TX_END: state_next = TX_IDLE;
        default: state_next = TX_IDLE;
      endcase
    end
  end

  always_comb begin
    shift_next = shift_reg;
    cnt_next   = cnt_reg;
    txd_next   = txd_reg;
    if (load) begin
      shift_next = {2'b11, load_byte, 1'b0};
      cnt_next   = `AHS_CHAR_SLOTS;
    end else if (tick && cnt_reg != 4'h0) begin
      txd_next   = shift_reg[0];
      shift_next = {1'b1, shift_reg[10:1]};
      cnt_next   = cnt_reg - 4'h1;
    end
    // Ready is offered only while a data character could be loaded next cycle
    ready_next = (state_next == TX_DATA) && (cnt_next == 4'h0) && enable && !flow_stop && !take;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= TX_IDLE;
      shift_reg <= 11'h7ff;
      cnt_reg   <= 4'h0;
      esc_reg   <= 8'h00;
      last_reg  <= 1'b0;
      txd_reg   <= 1'b1;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      cnt_reg   <= cnt_next;
      esc_reg   <= esc_next;
      last_reg  <= last_next;
      txd_reg   <= txd_next;
      ready_reg <= ready_next;
    end
  end

  assign char_ready   = ready_reg;
  assign txd          = txd_reg;
  assign frame_active = (state_reg != TX_IDLE);
  assign line_busy    = (cnt_reg != 4'h0);

endmodule

// File: testbench/ahs_chk_assertions.sv
// Purpose: Port-level checks of the async HDLC channel status block.
// Assumes: Status lags live state by one cycle; ctrl bit1 rx enable, option bit0 in-band.
// Notes:   Enable shadows are rebuilt from bus writes.
module ahs_chk (
  // Clock and reset
  input wire logic                 REF_CLK,
  input wire logic                 ARST_N,
  // Register port
  input wire logic [7:0]           REG_ADDR,
  input wire logic [7:0]           REG_WDATA,
  input wire logic                 REG_WR,
  input wire logic                 REG_RD,
  input wire logic [7:0]           REG_RDATA,
  // Line side
  input wire logic                 TX_CHAR_READY,
  input wire logic                 TXD,
  input wire logic                 RX_CHAR_VALID,
  input wire logic [7:0]           RX_CHAR,
  input wire logic                 RX_LINE_BUSY,
  input wire ahs_pkg::ahs_status_s STATUS
);
  timeunit 1ns;
  timeprecision 1ns;
  import ahs_pkg::*;
  logic rx_en_reg, rx_en_next, ib_reg, ib_next;
  always_comb begin
    rx_en_next = (REG_WR && REG_ADDR == 8'h00) ? REG_WDATA[1] : rx_en_reg;
    ib_next    = (REG_WR && REG_ADDR == 8'h01) ? REG_WDATA[0] : ib_reg;
  end
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_en_reg <= 1'b0;
      ib_reg    <= 1'b0;
    end else begin
      rx_en_reg <= rx_en_next;
      ib_reg    <= ib_next;
    end
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  a_tx_frame_excl: assert property (!(STATUS.tx_frame_active_flag && STATUS.tx_idle_flag))
    else $error("tx frame and tx idle both set");
  a_rx_frame_excl: assert property (!(STATUS.rx_frame_active_flag && STATUS.rx_idle_flag))
    else $error("rx frame and rx idle both set");
  a_rx_idle_follow: assert property ($past(ARST_N) |-> STATUS.rx_idle_flag == !$past(RX_LINE_BUSY))
    else $error("rx idle bit does not follow input");
  a_tx_en_follow: assert property (REG_WR && REG_ADDR == 8'h00 |-> ##2 STATUS.tx_enabled_flag == $past(REG_WDATA[0], 2))
    else $error("tx enable bit does not follow control");
  a_xoff_sets_flow: assert property (RX_CHAR_VALID && RX_CHAR == 8'h13 && rx_en_reg && ib_reg |-> ##2 STATUS.tx_flow_stopped_flag)
    else $error("xoff did not set flow stop");
  a_flow_blocks_tx: assert property (STATUS.tx_flow_stopped_flag && ib_reg && $past(ib_reg) |-> !TX_CHAR_READY)
    else $error("character taken while flow stopped");
  a_ready_needs_en: assert property (TX_CHAR_READY |-> STATUS.tx_enabled_flag)
    else $error("character taken while tx disabled");
  a_tx_idle_mark: assert property (STATUS.tx_idle_flag |-> $past(TXD))
    else $error("tx idle bit set while line active");
  a_status_read: assert property ($past(REG_RD) && $past(REG_ADDR) == 8'h02 |-> REG_RDATA == $past(STATUS))
    else $error("status read differs from status");
endmodule

bind ahs_channel_status ahs_chk u_chk (.REF_CLK, .ARST_N, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
  .TX_CHAR_READY, .TXD, .RX_CHAR_VALID, .RX_CHAR, .RX_LINE_BUSY, .STATUS);

// File: testbench/ahs_remote_station.sv
// Purpose: Remote station feeding the receive side of the channel.
// Assumes: Driven on rising edges of clk.
// Notes:   Character lines carry junk outside a valid pulse.
module ahs_remote_station (
  // Clock
  input wire logic  clk,
  // Receive side
  output logic       rx_char_valid,
  output logic [7:0] rx_char,
  output logic       rx_line_busy,
  output logic       rx_frame_active
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rx_char_valid = 1'b0;
    rx_char = 8'h5a;
    rx_line_busy = 1'b0;
    rx_frame_active = 1'b0;
  end
  task automatic send_char(input logic [7:0] c);
    @(posedge clk) rx_line_busy <= 1'b1;
    repeat (3) @(posedge clk);
    rx_char_valid <= 1'b1;
    rx_char <= c;
    @(posedge clk) rx_char_valid <= 1'b0;
    rx_char <= ~c;
    rx_line_busy <= 1'b0;
  endtask
  task automatic frame(input logic on);
    @(posedge clk) rx_line_busy <= on;
    rx_frame_active <= on;
  endtask
endmodule

// File: testbench/tb_top.sv
// Purpose: Register-level test of the async HDLC channel status block.
// Assumes: Bit time shortened to 4 clocks.
// Notes:   Status values expected are built from the bit layout.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ahs_pkg::*;
  logic        clk, arst_n, wr, rd, tx_valid, tx_ready, txd;
  logic [7:0]  addr, wdata, rdata;
  ahs_txchar_s tx_char;
  ahs_status_s status;
  logic        rx_valid, rx_busy, rx_frame;
  logic [7:0]  rx_char;
  int          bad_count, n_checks, k;
  ahs_channel_status #(.BAUD_DIV(4)) DUT (.REF_CLK(clk), .ARST_N(arst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .TX_CHAR_VALID(tx_valid), .TX_CHAR(tx_char),
    .TX_CHAR_READY(tx_ready), .TXD(txd), .RX_CHAR_VALID(rx_valid), .RX_CHAR(rx_char),
    .RX_LINE_BUSY(rx_busy), .RX_FRAME_ACTIVE(rx_frame), .STATUS(status));
  ahs_remote_station rs (.clk(clk), .rx_char_valid(rx_valid), .rx_char(rx_char), .rx_line_busy(rx_busy),
    .rx_frame_active(rx_frame));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) rd <= 1'b1;
    addr <= a;
    @(posedge clk) rd <= 1'b0;
    #1 chk("read data", exp, rdata);
  endtask
  task automatic wait_cond(input int sel);
    for (k = 0; k < 1000; k++) begin
      @(posedge clk);
      #1 if ((sel == 0) ? tx_ready === 1'b1 : status.tx_idle_flag === 1'b1) break;
    end
    if (k == 1000) begin
      chk("wait bound", 8'h00, 8'h01);
      end_sim();
    end
  endtask
  task automatic take_char();
    wait_cond(0);
    @(posedge clk) tx_valid <= 1'b0;
  endtask
  initial begin
    {wr, rd, tx_valid, addr, wdata} = '0;
    tx_char = '{last: 1'b1, data: 8'h7e};
    bad_count = 0;
    n_checks = 0;
    arst_n = 1'b0;
    @(posedge clk);
    #1 chk("status in reset", 8'h00, status);
    @(posedge clk) arst_n <= 1'b1;
    rd_reg(8'h02, 8'h11);
    rd_reg(8'h05, 8'h00);
    wr_reg(8'h00, 8'h03);
    rd_reg(8'h02, 8'h99);
    @(posedge clk) tx_valid <= 1'b1;
    take_char();
    rd_reg(8'h02, 8'h9a);
    wait_cond(1);
    rd_reg(8'h02, 8'h99);
    wr_reg(8'h01, 8'h01);
    rs.send_char(8'h13);
    rd_reg(8'h02, 8'h9d);
    @(posedge clk) tx_valid <= 1'b1;
    tx_char.data <= 8'h41;
    for (int j = 0; j < 200; j++) begin
      @(posedge clk);
      #1 chk("ready while flow stopped", 8'h00, {7'h00, tx_ready});
      chk("line while flow stopped", 8'h01, {7'h00, txd});
    end
    rs.send_char(8'h11);
    take_char();
    wait_cond(1);
    rd_reg(8'h02, 8'h99);
    rs.frame(1'b1);
    repeat (2) @(posedge clk);
    rd_reg(8'h02, 8'ha9);
    rs.frame(1'b0);
    wr_reg(8'h00, 8'h02);
    wr_reg(8'h02, 8'hff);
    rd_reg(8'h02, 8'h91);
    end_sim();
  end
endmodule
